// file: rtl/mic_defs.vh
// Register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH
// ****************************************
// Register offsets
// ****************************************
`define MIC_ADDR_CTRL       8'h0B
`define MIC_ADDR_PFLAG      8'h0C
`define MIC_ADDR_PEN        8'h8C
`define MIC_ADDR_OPT        8'h81
`define MIC_ADDR_IST        8'h90
`define MIC_ADDR_IMSK       8'h91
// ****************************************
// Control, flag, enable and option register fields
// ****************************************
`define MIC_GLB_EN_BIT      7
`define MIC_PEIE_BIT        6
`define MIC_TOV_EN_BIT      5
`define MIC_EXT_EN_BIT      4
`define MIC_PCH_EN_BIT      3
`define MIC_TOV_FLAG_BIT    2
`define MIC_EXT_FLAG_BIT    1
`define MIC_PCH_FLAG_BIT    0
`define MIC_CMP_BIT         6
`define MIC_EDGE_BIT        6
// ****************************************
// Reset values, interrupt vector and timing
// ****************************************
`define MIC_CTRL_RST        8'h00
`define MIC_PFLAG_RST       8'h00
`define MIC_PEN_RST         8'h00
`define MIC_OPT_RST         8'hFF
`define MIC_VECTOR          13'h0004
`define MIC_PIPE_CYCLES     2
`endif

// file: rtl/mic_irq_ctrl.v
// Interrupt controller of a small 8-bit microcontroller
//
// The strobed register port was chosen for this implementation.
`include "mic_defs.vh"
module mic_irq_ctrl (
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        rst_i,
    // Register port
    input  wire [7:0]  addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    // Sources
    input  wire        ext_irq_pin_i,
    input  wire        timer_ovf_i,
    input  wire [3:0]  port_hi_i,
    input  wire        port_rd_i,
    input  wire        cmp_change_i,
    // Core sequencer
    input  wire        sleep_i,
    input  wire        return_from_irq_instr_i,
    input  wire        irq_off_instr_i,
    output reg         irq_take_o,
    output reg  [12:0] vector_o,
    output reg         push_o,
    output reg         nop_o,
    output reg         wake_o,
    output reg         irq_o
);
    // ****************************************
    // State
    // ****************************************
    reg  [7:0] ctrl_q;
    reg  [7:0] pflag_q;
    reg  [7:0] pen_q;
    reg  [7:0] opt_q;
    reg  [7:0] ist_q;
    reg  [7:0] imsk_q;
    reg        ext_pin_q;
    reg  [3:0] port_latch_q;
    reg  [1:0] pipe_q;
    reg        asleep_q;
    reg        wake_vec_q;

    function sel;
        input [7:0] a;
        input [7:0] b;
        begin
            sel = (a == b);
        end
    endfunction

    // ****************************************
    // Event detection
    // ****************************************
    wire ext_edge = opt_q[`MIC_EDGE_BIT] ? (ext_irq_pin_i & ~ext_pin_q)
                                           : (~ext_irq_pin_i & ext_pin_q);
    wire port_chg = |(port_hi_i ^ port_latch_q);
    wire tmr_ev   = timer_ovf_i;
    wire cmp_ev   = cmp_change_i;
    // Four sources only, each with its own enable
    wire [3:0] pend = { ctrl_q[`MIC_TOV_FLAG_BIT] & ctrl_q[`MIC_TOV_EN_BIT],
                        ctrl_q[`MIC_EXT_FLAG_BIT] & ctrl_q[`MIC_EXT_EN_BIT],
                        ctrl_q[`MIC_PCH_FLAG_BIT] & ctrl_q[`MIC_PCH_EN_BIT],
                        pflag_q[`MIC_CMP_BIT] & pen_q[`MIC_CMP_BIT]
                          & ctrl_q[`MIC_PEIE_BIT] };
    wire any_pend = |pend;
    // Blocked in the no-op cycle so a cleared enable cannot race the accept
    wire accept = ctrl_q[`MIC_GLB_EN_BIT] & any_pend & ~asleep_q & ~nop_o
                  & ~irq_off_instr_i & (pipe_q == 2'd0);

    wire w_ctrl  = wr_i & sel(addr_i, `MIC_ADDR_CTRL);
    wire w_pflag = wr_i & sel(addr_i, `MIC_ADDR_PFLAG);

    // ****************************************
    // Registers
    // ****************************************
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q       <= `MIC_CTRL_RST;
            pflag_q      <= `MIC_PFLAG_RST;
            pen_q        <= `MIC_PEN_RST;
            opt_q        <= `MIC_OPT_RST;
            ist_q        <= 8'h00;
            imsk_q       <= 8'h00;
            ext_pin_q    <= 1'b0;
            port_latch_q <= 4'h0;
            pipe_q       <= 2'd0;
            asleep_q     <= 1'b0;
            wake_vec_q   <= 1'b0;
            irq_take_o   <= 1'b0;
            vector_o     <= 13'h0000;
            push_o       <= 1'b0;
            nop_o        <= 1'b0;
            wake_o       <= 1'b0;
            irq_o        <= 1'b0;
            rdata_o      <= 8'h00;
        end else begin
            ext_pin_q <= ext_irq_pin_i;
            if (port_rd_i) begin
                port_latch_q <= port_hi_i;
            end
            // Software writes first, hardware sets override
            if (w_ctrl) begin
                ctrl_q <= wdata_i;
            end
            if (return_from_irq_instr_i) begin
                ctrl_q[`MIC_GLB_EN_BIT] <= 1'b1;
            end
            if (irq_off_instr_i | accept) begin
                ctrl_q[`MIC_GLB_EN_BIT] <= 1'b0;
            end
            if (ext_edge) begin
                ctrl_q[`MIC_EXT_FLAG_BIT] <= 1'b1;
            end
            if (tmr_ev) begin
                ctrl_q[`MIC_TOV_FLAG_BIT] <= 1'b1;
            end
            if (port_chg) begin
                ctrl_q[`MIC_PCH_FLAG_BIT] <= 1'b1;
            end
            if (w_pflag) begin
                pflag_q <= wdata_i;
            end
            if (cmp_ev) begin
                pflag_q[`MIC_CMP_BIT] <= 1'b1;
            end
            if (wr_i & sel(addr_i, `MIC_ADDR_PEN)) begin
                pen_q <= wdata_i;
            end
            if (wr_i & sel(addr_i, `MIC_ADDR_OPT)) begin
                opt_q <= wdata_i;
            end
            if (wr_i & sel(addr_i, `MIC_ADDR_IMSK)) begin
                imsk_q <= wdata_i;
            end
            // Status: set wins over write-one clear
            ist_q <= ((wr_i & sel(addr_i, `MIC_ADDR_IST)) ? (ist_q & ~wdata_i) : ist_q)
                     | {4'h0, cmp_ev, port_chg, ext_edge, tmr_ev};
            irq_o <= |(ist_q & imsk_q);
            nop_o <= irq_off_instr_i;

            // Sleep and wake
            wake_o <= 1'b0;
            if (sleep_i & ~any_pend) begin
                asleep_q <= 1'b1;
            end else if (asleep_q & any_pend) begin
                asleep_q   <= 1'b0;
                wake_o     <= 1'b1;
                wake_vec_q <= ctrl_q[`MIC_GLB_EN_BIT];
            end

            // Fixed latency: event-to-flag 1, then pipe to vector
            irq_take_o <= 1'b0;
            push_o     <= 1'b0;
            if (wake_vec_q & ~asleep_q & (pipe_q == 2'd0)) begin
                wake_vec_q <= 1'b0;
                pipe_q     <= 2'd1;
                ctrl_q[`MIC_GLB_EN_BIT] <= 1'b0;
            end else if (accept) begin
                pipe_q <= 2'd1;
            end else if (pipe_q == `MIC_PIPE_CYCLES) begin
                pipe_q     <= 2'd0;
                irq_take_o <= 1'b1;
                push_o     <= 1'b1;
                vector_o   <= `MIC_VECTOR;
            end else if (pipe_q != 2'd0) begin
                pipe_q <= pipe_q + 2'd1;
            end

            // Read data one cycle later
            rdata_o <= 8'h00;
            if (rd_i) begin
                case (addr_i)
                    `MIC_ADDR_CTRL:  rdata_o <= ctrl_q;
                    `MIC_ADDR_PFLAG: rdata_o <= pflag_q & 8'h40;
                    `MIC_ADDR_PEN:   rdata_o <= pen_q & 8'h40;
                    `MIC_ADDR_OPT:   rdata_o <= opt_q;
                    `MIC_ADDR_IST:   rdata_o <= ist_q;
                    `MIC_ADDR_IMSK:  rdata_o <= imsk_q;
                    default:         rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule // mic_irq_ctrl

// file: tb/mic_irq_ctrl_asserts.sv
// Port checker of the interrupt controller
`include "mic_defs.vh"
module mic_irq_ctrl_asserts (
    input wire sys_clk_i, rst_i, wr_i, rd_i, ext_irq_pin_i, timer_ovf_i, port_rd_i,
    input wire cmp_change_i, sleep_i, return_from_irq_instr_i, irq_off_instr_i,
    input wire irq_take_o, push_o, nop_o, wake_o, irq_o,
    input wire [7:0] addr_i, wdata_i, rdata_o,
    input wire [3:0] port_hi_i,
    input wire [12:0] vector_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_take_push: assert property (irq_take_o == push_o)
        else $error("push apart from take");
    a_take_vector: assert property (irq_take_o |=> vector_o == `MIC_VECTOR)
        else $error("bad vector");
    a_take_once: assert property (irq_take_o ##1 (!return_from_irq_instr_i && !wr_i)[*2]
        |-> !irq_take_o) else $error("take repeated");
    a_nop_follow: assert property (irq_off_instr_i |=> nop_o)
        else $error("no nop");
    a_nop_cause: assert property (nop_o |-> $past(irq_off_instr_i))
        else $error("stray nop");
    a_nop_blocks: assert property (nop_o |-> !irq_take_o)
        else $error("take in nop");
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data stands");
    a_pen_bits: assert property (rd_i && addr_i == `MIC_ADDR_PEN |=> (rdata_o & 8'hBF) == 8'h00)
        else $error("enable bits");
    c_take: cover property (irq_take_o);
    c_wake: cover property (wake_o);
    c_nop: cover property (nop_o);
endmodule // mic_irq_ctrl_asserts
bind mic_irq_ctrl mic_irq_ctrl_asserts i_mic_irq_ctrl_asserts (.*);

// file: tb/mic_core_model.sv
// Core sequencer model: returns from service a fixed time after a take
module mic_core_model #(parameter int SVC = 8) (
    input  wire  sys_clk_i, rst_i, take_i,
    output logic ret_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always @(posedge sys_clk_i or posedge rst_i)
        if (rst_i) begin
            cnt <= 0;
            ret_o <= 0;
        end else begin
            ret_o <= cnt == 1;
            cnt <= take_i ? SVC : (cnt > 0 ? cnt - 1 : 0);
        end
endmodule // mic_core_model

// file: tb/testbench.sv
// Self-checking bench of the interrupt controller
`include "mic_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, wr = 0, rd = 0, pin = 0, ret, take, push, nop, wake, irq;
    logic [7:0] addr = 0, wdata = 0, rdata, seed = 8'h05;
    logic [3:0] port = 0;
    logic [4:0] pls = 0;
    logic [12:0] vec;
    int fail_count = 0, total_checks = 0, cyc = 0, n;
    always #2.5 clk = ~clk;
    mic_irq_ctrl i_mic_irq_ctrl (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_irq_pin_i(pin), .timer_ovf_i(pls[0]),
        .port_hi_i(port), .port_rd_i(pls[1]), .cmp_change_i(pls[2]), .sleep_i(pls[3]),
        .return_from_irq_instr_i(ret), .irq_off_instr_i(pls[4]), .irq_take_o(take),
        .vector_o(vec), .push_o(push), .nop_o(nop), .wake_o(wake), .irq_o(irq));
    mic_core_model i_mic_core_model (.sys_clk_i(clk), .rst_i(rst), .take_i(take), .ret_o(ret));
    function automatic [7:0] lfsr(input [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input [7:0] got, input [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input [7:0] a, input [7:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 0;
    endtask
    task automatic rreg(input [7:0] a, input [7:0] e);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 0;
        #1 chk(rdata, e);
    endtask
    task automatic pulse(input int b);
        @(posedge clk) pls[b] <= 1;
        @(posedge clk) pls[b] <= 0;
    endtask
    task automatic rise;
        @(posedge clk) pin <= 0;
        @(posedge clk) pin <= 1;
    endtask
    // Cycles from the event edge until take or wake, 20 if none
    task automatic wait_ev(input bit w, output int k);
        k = 0;
        do begin @(posedge clk); #1 k++; end while ((w ? wake : take) !== 1'b1 && k < 20);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            stop_test;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        rreg(`MIC_ADDR_CTRL, 8'h00);
        rreg(`MIC_ADDR_OPT, 8'hFF);
        rreg(8'h00, 8'h00);
        @(posedge clk) pin <= 1;
        pulse(0);
        pulse(1);
        @(posedge clk) port <= 4'hA;
        pulse(2);
        rreg(`MIC_ADDR_CTRL, 8'h07);
        rreg(`MIC_ADDR_PFLAG, 8'h40);
        rreg(`MIC_ADDR_IST, 8'h0F);
        wreg(`MIC_ADDR_IMSK, 8'h02);
        @(posedge clk) #1 chk(8'(irq), 1);
        wreg(`MIC_ADDR_IST, 8'h02);
        @(posedge clk) #1 chk(8'(irq), 0);
        wreg(`MIC_ADDR_IMSK, 8'h00);
        pulse(1);
        wreg(`MIC_ADDR_CTRL, 8'h80);
        pulse(0);
        wait_ev(0, n);
        chk(8'(n), 20);
        wreg(`MIC_ADDR_CTRL, 8'h10);
        rise;
        wait_ev(0, n);
        chk(8'(n), 20);
        wreg(`MIC_ADDR_CTRL, 8'h90);
        rise;
        wait_ev(0, n);
        chk(8'(n > 2 && n < 5), 1);
        rreg(`MIC_ADDR_CTRL, 8'h12);
        wreg(`MIC_ADDR_CTRL, 8'h10);
        repeat (8) @(posedge clk);
        rreg(`MIC_ADDR_CTRL, 8'h90);
        pulse(4);
        wreg(`MIC_ADDR_CTRL, 8'h10);
        pulse(3);
        rise;
        wait_ev(1, n);
        chk(8'(n < 20), 1);
        rreg(`MIC_ADDR_CTRL, 8'h12);
        repeat (6) begin
            seed = lfsr(seed);
            wreg(`MIC_ADDR_PEN, seed);
            rreg(`MIC_ADDR_PEN, seed & 8'h40);
        end
        stop_test;
    end
endmodule // testbench
